// ===== verilog/hdm_map.vh
// Register offsets, field positions, reset values and sizes for the host and E1 front end
`ifndef HDM_MAP_VH
`define HDM_MAP_VH

// ==========================================
// Host port
`define HDM_ADDR_W 7
`define HDM_DATA_W 8
`define HDM_REG_CNT 128
`define HDM_BYTE_ZERO 8'h00

// ==========================================
// Register offsets
`define HDM_OFS_CTRL 7'h00
`define HDM_OFS_FRM_MASK 7'h01
`define HDM_OFS_FRM_STAT 7'h02
`define HDM_OFS_GEN_MASK 7'h03
`define HDM_OFS_GEN_STAT 7'h04
`define HDM_OFS_E1_LAST 7'h05
`define HDM_OFS_E1_STAT 7'h06

// ==========================================
// Control register fields
`define HDM_CTRL_RST 8'h01
`define HDM_CTRL_EDGE_INV 0
`define HDM_CTRL_LINES_LO 1
`define HDM_CTRL_LINES_HI 2
`define HDM_CTRL_UNFRAMED 3

// ==========================================
// Frame-period status bits
`define HDM_FRM_MUX_OH 0
`define HDM_FRM_DEMUX_OH 1
`define HDM_FRM_TRIPLE 2
`define HDM_FRM_W 3
`define HDM_FRM_ZERO 3'h0

// ==========================================
// General status: bit 7 is the E1 buffer overflow, low bits come from the core
`define HDM_GEN_OVF 7
`define HDM_GEN_CORE_W 7

// ==========================================
// E1 byte assembly
`define HDM_BIT_CNT_W 3
`define HDM_BIT_LAST 3'h7
`define HDM_BIT_FIRST 3'h1
`define HDM_BUF_W 9
`define HDM_BUF_DEPTH 2

// ==========================================
// Host access states
`define HDM_ST_W 2

`endif

// ===== verilog/hdm_pair_buf.v
// Two-entry buffer with valid/ready on both sides
`timescale 1ns/1ps
`include "hdm_map.vh"

module hdm_pair_buf #(
  parameter WIDTH = `HDM_BUF_W
) (
  input wire clk,
  input wire srst,
  input wire in_valid,
  output wire in_ready,
  input wire [WIDTH-1:0] in_data,
  output wire out_valid,
  input wire out_ready,
  output wire [WIDTH-1:0] out_data
);

  reg [WIDTH-1:0] mem_ff [0:`HDM_BUF_DEPTH-1];
  reg wr_ptr_ff;
  reg rd_ptr_ff;
  reg [1:0] count_ff;
  wire push;
  wire pop;

  // ==========================================
  // Flags
  assign in_ready = (count_ff != 2'h2);
  assign out_valid = (count_ff != 2'h0);
  assign push = in_valid & in_ready;
  assign pop = out_valid & out_ready;
  // Output comes straight from the storage flops
  assign out_data = mem_ff[rd_ptr_ff];

  // ==========================================
  // Storage and pointers
  always @(posedge clk) begin
    if (srst) begin
      wr_ptr_ff <= 1'b0;
      rd_ptr_ff <= 1'b0;
      count_ff <= 2'h0;
    end else begin
      if (push) begin
        wr_ptr_ff <= ~wr_ptr_ff;
      end
      if (pop) begin
        rd_ptr_ff <= ~rd_ptr_ff;
      end
      count_ff <= count_ff + {1'b0, push} - {1'b0, pop};
    end
  end

  always @(posedge clk) begin
    if (push) begin
      mem_ff[wr_ptr_ff] <= in_data;
    end
  end

endmodule // hdm_pair_buf

// ===== verilog/hdm_host_e1.v
// Host parallel port, serial E1 mux input and interrupt outputs of the framer/mapper
`timescale 1ns/1ps
`include "hdm_map.vh"

// Functional notes
// - With bus_style_select high the write strobe is read/write and the read strobe a data strobe, else both are separate strobes.
// - In separate-strobe mode a low read strobe with low chip select drives the addressed register onto the data bus.
// - The host data path is an 8-bit two-way bus with tri-state outputs.
// - In separate-strobe mode a low write strobe with low chip select captures the data bus into the addressed register.
// - E1 data and frame mark are sampled on the E1 clock, on the edge chosen by a control bit.
// - A low reset pin returns all circuits and control registers to their defaults.
// - The frame-period interrupt goes low, when enabled, on mux overhead ready, demux overhead ready or a triple-repeat match.
// - The general interrupt is active low and asserts, when enabled, on any general condition.
// - Both interrupt outputs are timed by the HDSL frame rate.
// - The E1 stream, framed or unframed, is carried to and from one to three HDSL lines.
module hdm_host_e1 (
  input wire clk,
  input wire srst,
  input wire reset_pin_n,
  input wire bus_style_select,
  input wire chip_select_n,
  input wire write_strobe_n,
  input wire read_strobe_n,
  input wire [`HDM_ADDR_W-1:0] host_addr,
  input wire [`HDM_DATA_W-1:0] host_data_in,
  output wire [`HDM_DATA_W-1:0] host_data_out,
  output wire host_data_oe_n,
  input wire mux_line_clock_in,
  input wire mux_line_data_in,
  input wire mux_frame_mark_in,
  output wire [`HDM_DATA_W-1:0] e1_byte_data,
  output wire e1_byte_first,
  output wire e1_byte_valid,
  input wire e1_byte_ready,
  output wire [1:0] active_line_count,
  output wire unframed_mode,
  input wire hdsl_frame_tick,
  input wire mux_oh_ready,
  input wire demux_oh_ready,
  input wire triple_match,
  input wire [`HDM_GEN_CORE_W-1:0] gen_events,
  output wire frame_period_irq_n,
  output wire general_irq_n
);

  localparam ST_IDLE = 2'b00;
  localparam ST_READ = 2'b01;
  localparam ST_WRITE = 2'b10;

  // ==========================================
  // Pin synchronisers: every pin crosses two flops before use
  reg [6:0] pin_s1_ff;
  reg [6:0] pin_s2_ff;
  reg [`HDM_ADDR_W-1:0] addr_s1_ff;
  reg [`HDM_ADDR_W-1:0] addr_s2_ff;
  reg [`HDM_DATA_W-1:0] wdat_s1_ff;
  reg [`HDM_DATA_W-1:0] wdat_s2_ff;
  reg e1_clk_prev_ff;

  always @(posedge clk) begin
    pin_s1_ff <= {reset_pin_n, bus_style_select, chip_select_n, write_strobe_n,
                  read_strobe_n, mux_line_clock_in, mux_line_data_in};
    pin_s2_ff <= pin_s1_ff;
    addr_s1_ff <= host_addr;
    addr_s2_ff <= addr_s1_ff;
    wdat_s1_ff <= host_data_in;
    wdat_s2_ff <= wdat_s1_ff;
  end

  reg mark_s1_ff;
  reg mark_s2_ff;
  always @(posedge clk) begin
    mark_s1_ff <= mux_frame_mark_in;
    mark_s2_ff <= mark_s1_ff;
  end

  wire rst_i = srst | ~pin_s2_ff[6];
  wire style_rw = pin_s2_ff[5];
  wire cs_n_s = pin_s2_ff[4];
  wire wr_n_s = pin_s2_ff[3];
  wire rd_n_s = pin_s2_ff[2];
  wire e1_clk_s = pin_s2_ff[1];
  wire e1_dat_s = pin_s2_ff[0];

  // ==========================================
  // Bus style decode; chip select high masks both strobes
  wire rd_act = ~cs_n_s & ~rd_n_s & (~style_rw | wr_n_s);
  wire wr_act = ~cs_n_s & (style_rw ? (~rd_n_s & ~wr_n_s) : ~wr_n_s);

  // ==========================================
  // Register file
  reg [`HDM_DATA_W-1:0] regs_ff [0:`HDM_REG_CNT-1];
  reg [`HDM_DATA_W-1:0] ctrl_ff;
  reg [`HDM_FRM_W-1:0] frm_mask_ff;
  reg [`HDM_FRM_W-1:0] frm_stat_ff;
  reg [`HDM_DATA_W-1:0] gen_mask_ff;
  reg [`HDM_DATA_W-1:0] gen_stat_ff;
  reg [`HDM_DATA_W-1:0] e1_last_ff;
  reg e1_synced_ff;
  reg [`HDM_ST_W-1:0] st_ff;
  reg [`HDM_ST_W-1:0] nxt_st;
  reg [`HDM_DATA_W-1:0] dout_ff;
  reg oe_n_ff;
  reg frm_irq_n_ff;
  reg gen_irq_n_ff;
  integer i;

  function hit;
    input [`HDM_ADDR_W-1:0] a;
    input [`HDM_ADDR_W-1:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  function [`HDM_DATA_W-1:0] rd_value;
    input [`HDM_ADDR_W-1:0] a;
    begin
      if (hit(a, `HDM_OFS_CTRL)) rd_value = ctrl_ff;
      else if (hit(a, `HDM_OFS_FRM_MASK)) rd_value = {5'h00, frm_mask_ff};
      else if (hit(a, `HDM_OFS_FRM_STAT)) rd_value = {5'h00, frm_stat_ff};
      else if (hit(a, `HDM_OFS_GEN_MASK)) rd_value = gen_mask_ff;
      else if (hit(a, `HDM_OFS_GEN_STAT)) rd_value = gen_stat_ff;
      else if (hit(a, `HDM_OFS_E1_LAST)) rd_value = e1_last_ff;
      else if (hit(a, `HDM_OFS_E1_STAT)) rd_value = {7'h00, e1_synced_ff};
      else rd_value = regs_ff[a];
    end
  endfunction

  // ==========================================
  // Host access sequencer: one write per strobe, read data refreshed while held
  always @* begin
    case (st_ff)
      ST_IDLE: nxt_st = rd_act ? ST_READ : (wr_act ? ST_WRITE : ST_IDLE);
      ST_READ: nxt_st = rd_act ? ST_READ : ST_IDLE;
      ST_WRITE: nxt_st = wr_act ? ST_WRITE : ST_IDLE;
      default: nxt_st = ST_IDLE;
    endcase
  end

  wire wr_fire = (st_ff == ST_IDLE) & ~rd_act & wr_act;
  wire [`HDM_ADDR_W-1:0] wa = addr_s2_ff;

  always @(posedge clk) begin
    if (rst_i) begin
      st_ff <= ST_IDLE;
      dout_ff <= `HDM_BYTE_ZERO;
      oe_n_ff <= 1'b1;
    end else begin
      st_ff <= nxt_st;
      // Bus released on the clock after the synchronised read strobe ends, so the host may drive
      oe_n_ff <= ~rd_act;
      if (rd_act) begin
        dout_ff <= rd_value(addr_s2_ff);
      end
    end
  end

  assign host_data_out = dout_ff;
  assign host_data_oe_n = oe_n_ff;

  // ==========================================
  // E1 sampling edge and byte assembly
  wire mux_clock_edge_invert = ctrl_ff[`HDM_CTRL_EDGE_INV];
  wire e1_rise = e1_clk_s & ~e1_clk_prev_ff;
  wire e1_fall = ~e1_clk_s & e1_clk_prev_ff;
  wire e1_sample = mux_clock_edge_invert ? e1_fall : e1_rise;

  reg [`HDM_DATA_W-1:0] shift_ff;
  reg [`HDM_BIT_CNT_W-1:0] bit_cnt_ff;
  reg first_pend_ff;
  reg push_ff;
  reg push_first_ff;
  reg [`HDM_DATA_W-1:0] push_data_ff;
  wire buf_in_ready;
  wire [`HDM_DATA_W-1:0] nxt_shift = {shift_ff[`HDM_DATA_W-2:0], e1_dat_s};

  always @(posedge clk) begin
    if (rst_i) begin
      e1_clk_prev_ff <= 1'b0;
      shift_ff <= `HDM_BYTE_ZERO;
      bit_cnt_ff <= {`HDM_BIT_CNT_W{1'b0}};
      first_pend_ff <= 1'b0;
      push_ff <= 1'b0;
      push_first_ff <= 1'b0;
      push_data_ff <= `HDM_BYTE_ZERO;
      e1_last_ff <= `HDM_BYTE_ZERO;
      e1_synced_ff <= 1'b0;
    end else begin
      e1_clk_prev_ff <= e1_clk_s;
      push_ff <= 1'b0;
      if (e1_sample) begin
        shift_ff <= nxt_shift;
        // Frame mark pins this bit as bit 0 of time slot 0
        if (mark_s2_ff) begin
          bit_cnt_ff <= `HDM_BIT_FIRST;
          first_pend_ff <= 1'b1;
          e1_synced_ff <= 1'b1;
        end else begin
          bit_cnt_ff <= bit_cnt_ff + `HDM_BIT_FIRST;
        end
        if (bit_cnt_ff == `HDM_BIT_LAST && !mark_s2_ff) begin
          push_ff <= 1'b1;
          push_first_ff <= first_pend_ff;
          push_data_ff <= nxt_shift;
          e1_last_ff <= nxt_shift;
          first_pend_ff <= 1'b0;
        end
      end
    end
  end

  // A serial line cannot be stalled: a full buffer drops the byte and flags overflow
  wire overflow = push_ff & ~buf_in_ready;

  hdm_pair_buf #(
    .WIDTH(`HDM_BUF_W)
  ) u_buf (
    .clk(clk),
    .srst(rst_i),
    .in_valid(push_ff),
    .in_ready(buf_in_ready),
    .in_data({push_first_ff, push_data_ff}),
    .out_valid(e1_byte_valid),
    .out_ready(e1_byte_ready),
    .out_data({e1_byte_first, e1_byte_data})
  );

  assign active_line_count = ctrl_ff[`HDM_CTRL_LINES_HI:`HDM_CTRL_LINES_LO];
  assign unframed_mode = ctrl_ff[`HDM_CTRL_UNFRAMED];

  // ==========================================
  // Register writes and sticky status; an event in the clearing cycle wins
  wire [`HDM_FRM_W-1:0] frm_ev = {triple_match, demux_oh_ready, mux_oh_ready};
  wire [`HDM_DATA_W-1:0] gen_ev = {overflow, gen_events};

  always @(posedge clk) begin
    if (rst_i) begin
      ctrl_ff <= `HDM_BYTE_ZERO;
      frm_mask_ff <= `HDM_FRM_ZERO;
      frm_stat_ff <= `HDM_FRM_ZERO;
      gen_mask_ff <= `HDM_BYTE_ZERO;
      gen_stat_ff <= `HDM_BYTE_ZERO;
      for (i = 0; i < `HDM_REG_CNT; i = i + 1) begin
        regs_ff[i] <= `HDM_BYTE_ZERO;
      end
    end else begin
      if (wr_fire && hit(wa, `HDM_OFS_CTRL)) ctrl_ff <= wdat_s2_ff;
      if (wr_fire && hit(wa, `HDM_OFS_FRM_MASK)) frm_mask_ff <= wdat_s2_ff[`HDM_FRM_W-1:0];
      if (wr_fire && hit(wa, `HDM_OFS_GEN_MASK)) gen_mask_ff <= wdat_s2_ff;
      if (wr_fire) regs_ff[wa] <= wdat_s2_ff;
      if (wr_fire && hit(wa, `HDM_OFS_FRM_STAT)) begin
        frm_stat_ff <= (frm_stat_ff & ~wdat_s2_ff[`HDM_FRM_W-1:0]) | frm_ev;
      end else begin
        frm_stat_ff <= frm_stat_ff | frm_ev;
      end
      if (wr_fire && hit(wa, `HDM_OFS_GEN_STAT)) begin
        gen_stat_ff <= (gen_stat_ff & ~wdat_s2_ff) | gen_ev;
      end else begin
        gen_stat_ff <= gen_stat_ff | gen_ev;
      end
    end
  end

  // ==========================================
  // Interrupt outputs move only on the HDSL frame tick
  always @(posedge clk) begin
    if (rst_i) begin
      frm_irq_n_ff <= 1'b1;
      gen_irq_n_ff <= 1'b1;
    end else if (hdsl_frame_tick) begin
      frm_irq_n_ff <= ~(|(frm_stat_ff & frm_mask_ff));
      gen_irq_n_ff <= ~(|(gen_stat_ff & gen_mask_ff));
    end
  end

  assign frame_period_irq_n = frm_irq_n_ff;
  assign general_irq_n = gen_irq_n_ff;

endmodule // hdm_host_e1

// ===== sim/hdm_props.sv
// Checker for the host port, E1 buffer and interrupt pins
`timescale 1ns/1ps
`include "hdm_map.vh"
module hdm_props (
  input wire clk,
  input wire srst,
  input wire reset_pin_n,
  input wire bus_style_select,
  input wire chip_select_n,
  input wire write_strobe_n,
  input wire read_strobe_n,
  input wire host_data_oe_n,
  input wire [`HDM_DATA_W-1:0] e1_byte_data,
  input wire e1_byte_first,
  input wire e1_byte_valid,
  input wire e1_byte_ready,
  input wire [1:0] active_line_count,
  input wire unframed_mode,
  input wire hdsl_frame_tick,
  input wire frame_period_irq_n,
  input wire general_irq_n
);
  // ==========================================
  // Strobes pass two sync flops and one register
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst || !reset_pin_n);
  cs_ignore_a: assert property (chip_select_n [*4] |-> host_data_oe_n)
    else $error("bus driven without select");
  no_read_a: assert property (
    (read_strobe_n || (bus_style_select && !write_strobe_n)) [*4] |-> host_data_oe_n)
    else $error("bus driven outside a read");
  sep_read_a: assert property (
    (!bus_style_select && !chip_select_n && !read_strobe_n) [*4] |-> !host_data_oe_n)
    else $error("separate read not driven");
  strobe_read_a: assert property (
    (bus_style_select && !chip_select_n && !read_strobe_n && write_strobe_n) [*4]
    |-> !host_data_oe_n)
    else $error("strobe read not driven");
  oe_cause_a: assert property (
    $fell(host_data_oe_n) |-> $past(!chip_select_n && !read_strobe_n, 2))
    else $error("drive without read");
  frm_tick_a: assert property (!$stable(frame_period_irq_n) |-> $past(hdsl_frame_tick))
    else $error("frame irq off tick");
  gen_tick_a: assert property (!$stable(general_irq_n) |-> $past(hdsl_frame_tick))
    else $error("general irq off tick");
  e1_hold_a: assert property (
    e1_byte_valid && !e1_byte_ready |=> e1_byte_valid
    && $stable(e1_byte_data) && $stable(e1_byte_first))
    else $error("stalled byte changed");
  rst_quiet_a: assert property (disable iff (!reset_pin_n) srst |=> host_data_oe_n
    && frame_period_irq_n && general_irq_n && !e1_byte_valid && !unframed_mode
    && active_line_count == 2'b00)
    else $error("outputs not reset");
endmodule // hdm_props

bind hdm_host_e1 hdm_props u_props (.clk, .srst, .reset_pin_n, .bus_style_select,
  .chip_select_n, .write_strobe_n, .read_strobe_n, .host_data_oe_n, .e1_byte_data,
  .e1_byte_first, .e1_byte_valid, .e1_byte_ready, .active_line_count, .unframed_mode,
  .hdsl_frame_tick, .frame_period_irq_n, .general_irq_n);

// ===== sim/hdm_host_mdl.sv
// Microprocessor model on the parallel host port
`timescale 1ns/1ps
module hdm_host_mdl (
  input wire clk,
  input wire ms,
  input wire [7:0] dout,
  output reg cs_n,
  output reg wr_n,
  output reg rd_n,
  output reg drv,
  output reg [6:0] addr,
  output reg [7:0] hd
);
  initial begin
    {cs_n, wr_n, rd_n, drv, addr, hd} = {3'h7, 1'b0, 7'h00, 8'h00};
  end
  // ==========================================
  // Address and data settle before the strobe since the device synchronises them
  task acc(input w, input [6:0] a, input [7:0] d, output [7:0] q);
    begin
      @(posedge clk);
      #1 addr = a;
      hd = d;
      drv = w;
      if (ms) wr_n = !w;
      repeat (3) @(posedge clk);
      #1 cs_n = 0;
      if (ms || !w) rd_n = 0;
      else wr_n = 0;
      repeat (6) @(posedge clk);
      q = dout;
      #1 {cs_n, rd_n, wr_n, drv} = 4'hE;
      repeat (4) @(posedge clk);
    end
  endtask
endmodule // hdm_host_mdl

// ===== sim/hdm_host_e1_bench.sv
// Self-checking bench for the host port, E1 input and interrupts
`timescale 1ns/1ps
`include "hdm_map.vh"
module hdm_host_e1_bench;
  reg clk = 0, srst = 1, pin_n = 1, bss = 0, ck = 0, e1d = 0, e1m = 0, rdy = 0, stall = 1;
  reg tick = 0, moh = 0, doh = 0, trm = 0;
  reg [6:0] gev = 0, a;
  reg [7:0] q, d;
  reg [8:0] expq [$];
  wire cs_n, wr_n, rd_n, drv, oe_n, vld, fst, frq_n, grq_n, ufm;
  wire [6:0] addr;
  wire [7:0] hd, dout, bdat;
  wire [1:0] lines;
  integer errors = 0, checks_done = 0, i, k;
  // Bus driven by neither side shows the inverse of the host model's hd, not the last read value
  wire [7:0] hin = !oe_n ? dout : (drv ? hd : ~hd);
  hdm_host_mdl host (.clk(clk), .ms(bss), .dout(hin), .cs_n(cs_n), .wr_n(wr_n),
    .rd_n(rd_n), .drv(drv), .addr(addr), .hd(hd));
  hdm_host_e1 uut (.clk(clk), .srst(srst), .reset_pin_n(pin_n), .bus_style_select(bss),
    .chip_select_n(cs_n), .write_strobe_n(wr_n), .read_strobe_n(rd_n), .host_addr(addr),
    .host_data_in(hin), .host_data_out(dout), .host_data_oe_n(oe_n),
    .mux_line_clock_in(ck), .mux_line_data_in(e1d), .mux_frame_mark_in(e1m),
    .e1_byte_data(bdat), .e1_byte_first(fst), .e1_byte_valid(vld), .e1_byte_ready(rdy),
    .active_line_count(lines), .unframed_mode(ufm), .hdsl_frame_tick(tick),
    .mux_oh_ready(moh), .demux_oh_ready(doh), .triple_match(trm), .gen_events(gev),
    .frame_period_irq_n(frq_n), .general_irq_n(grq_n));
  initial forever #20 clk = ~clk;
  // ==========================================
  // Tasks
  task chk(input [8:0] got, input [8:0] exp);
    begin
      checks_done = checks_done + 1;
      if (got !== exp) begin
        errors = errors + 1;
        $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
    end
  endtask
  task wr(input [6:0] wa, input [7:0] wd); host.acc(1'b1, wa, wd, q); endtask
  task rdc(input [6:0] ra, input [7:0] e);
    begin
      host.acc(1'b0, ra, 8'h00, q);
      chk({1'b0, q}, {1'b0, e});
    end
  endtask
  task e1_bit(input b, input m, input inv);
    begin
      @(posedge clk);
      #1 {ck, e1d, e1m} = {inv, b, m};
      repeat (6) @(posedge clk);
      #1 ck = !inv;
      repeat (5) @(posedge clk);
    end
  endtask
  task e1_byte(input [7:0] v, input f, input inv, input keep);
    begin
      for (k = 7; k >= 0; k = k - 1) e1_bit(v[k], f && k == 7, inv);
      if (keep) expq.push_back({f, v});
    end
  endtask
  task pulse(input [2:0] f, input [6:0] g, input t);
    begin
      @(posedge clk);
      #1 {trm, doh, moh, gev, tick} = {f, g, t};
      @(posedge clk);
      #1 {trm, doh, moh, gev, tick} = 11'h000;
    end
  endtask
  task final_report;
    begin
      $display("checks_done=%0d errors=%0d", checks_done, errors);
      if (errors == 0 && checks_done > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
    end
  endtask
  always @(posedge clk) begin
    if (vld === 1'b1 && rdy === 1'b1) begin
      if (expq.size() == 0) chk(9'h000, 9'h1FF);
      else chk({fst, bdat}, expq.pop_front());
    end
    #1 rdy = stall ? 1'b0 : (($urandom & 1) != 0);
  end
  initial begin
    repeat (20000) @(posedge clk);
    errors = errors + 1;
    final_report;
  end
  // ==========================================
  // Main sequence
  initial begin
    i = $urandom(22);
    repeat (20) @(posedge clk);
    #1 srst = 0;
    rdc(`HDM_OFS_CTRL, 8'h00);
    wr(`HDM_OFS_CTRL, 8'h0D);
    rdc(`HDM_OFS_CTRL, 8'h0D);
    chk({6'h00, ufm, lines}, 9'h006);
    stall = 0;
    for (k = 0; k < 3; k = k + 1) e1_bit(k == 0, k == 0, 1'b1);
    e1_byte(8'hA5, 1'b1, 1'b1, 1'b1);
    for (i = 0; i < 3; i = i + 1) e1_byte($urandom, 1'b0, 1'b1, 1'b1);
    // Drain first so the stalled bytes land in an empty buffer
    while (vld === 1'b1) @(posedge clk);
    stall = 1;
    for (i = 0; i < 3; i = i + 1) e1_byte($urandom, 1'b0, 1'b1, i < 2);
    rdc(`HDM_OFS_GEN_STAT, 8'h80);
    stall = 0;
    wr(`HDM_OFS_GEN_STAT, 8'h80);
    while (vld === 1'b1) @(posedge clk);
    chk(expq.size(), 9'h000);
    wr(`HDM_OFS_CTRL, 8'h00);
    e1_byte($urandom, 1'b1, 1'b0, 1'b1);
    e1_byte($urandom, 1'b0, 1'b0, 1'b1);
    for (i = 0; i < 6; i = i + 1) begin
      #1 bss = i[0];
      a = 7'h07 + $urandom % 121;
      d = $urandom;
      wr(a, d);
      rdc(a, d);
    end
    #1 bss = 0;
    wr(`HDM_OFS_FRM_MASK, 8'h07);
    for (i = 0; i < 3; i = i + 1) begin
      pulse(3'h1 << i, 7'h00, 1'b0);
      pulse(3'h0, 7'h00, 1'b1);
      chk({8'h00, frq_n}, 9'h000);
      wr(`HDM_OFS_FRM_STAT, 8'h07);
      pulse(3'h0, 7'h00, 1'b1);
      chk({8'h00, frq_n}, 9'h001);
    end
    d = {1'b0, 7'h01 + $urandom % 127};
    pulse(3'h0, d[6:0], 1'b1);
    pulse(3'h0, 7'h00, 1'b1);
    chk({8'h00, grq_n}, 9'h001);
    wr(`HDM_OFS_GEN_MASK, 8'h7F);
    pulse(3'h0, 7'h00, 1'b1);
    chk({8'h00, grq_n}, 9'h000);
    rdc(`HDM_OFS_GEN_STAT, d);
    // Every byte sent since the mode change must have come out
    chk(expq.size(), 9'h000);
    @(posedge clk);
    #1 srst = 1;
    repeat (2) @(posedge clk);
    #1 srst = 0;
    rdc(`HDM_OFS_GEN_MASK, 8'h00);
    wr(`HDM_OFS_CTRL, 8'h0E);
    #1 pin_n = 0;
    repeat (5) @(posedge clk);
    #1 pin_n = 1;
    rdc(`HDM_OFS_CTRL, 8'h00);
    final_report;
  end
endmodule // hdm_host_e1_bench
